// File: rtl/rate_adapter_pkg.sv
// shared constants, types and register map of the cell rate adapter control
package rate_adapter_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int SEC_CYCLES = NS_PER_S / CLK_PERIOD_NS;
  localparam int LOOP_LED_S = 5;
  localparam int BUTTON_HOLD_S = 1;
  localparam int LOOP_AUTO_S = 3600;
  localparam int SELFTEST_TRIES = 3;

  // bipolar violation relay limit: one per 10^5 slow-line bits
  localparam longint SLOW_LINE_BPS = 64'd6312000;
  localparam longint BPV_BITS_PER_ERR = 64'd100000;
  localparam int BPV_GAP_CYCLES =
    int'((longint'(SEC_CYCLES) * BPV_BITS_PER_ERR) / SLOW_LINE_BPS);

  // burst buffer
  localparam int CELL_BURST = 70;
  localparam int CELL_DEPTH = 75;

  // register byte addresses
  localparam logic [7:0] ADDR_OVERRIDE = 8'h00;
  localparam logic [7:0] ADDR_SYNC = 8'h04;
  localparam logic [7:0] ADDR_LOOP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_HEC_CNT = 8'h10;
  localparam logic [7:0] ADDR_CELL_CNT = 8'h14;
  localparam logic [7:0] ADDR_BPV_CNT = 8'h18;
  localparam logic [7:0] ADDR_CLEAR = 8'h1C;

  // field positions
  localparam int LOOP_STOP_BIT = 31;
  localparam int SYNC_ARG_SLOW = 0;
  localparam int SYNC_ARG_FAST = 1;
  localparam int SYNC_ARG_INT = 2;

  // reset values
  localparam logic [11:0] OPTION_RESET = 12'h000;
  localparam logic [1:0] GUARD_RESET = 2'h3;

  typedef struct packed {
    logic ais;
    logic rai;
    logic los;
    logic lof;
  } alarm_type;

  typedef enum logic [1:0] {TIME_INTERNAL, TIME_FAST, TIME_SLOW} timing_type;
  typedef enum logic [1:0] {CABLE_SHORT, CABLE_MEDIUM, CABLE_LONG} cable_type;
  typedef enum {ST_RUN, ST_WAIT, ST_LOOP_LED, ST_DONE} selftest_type;

endpackage : rate_adapter_pkg

// File: rtl/rate_adapter_ctrl.sv
// control logic of the fast-to-slow ATM cell rate adapter
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
module rate_adapter_ctrl
  import rate_adapter_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int BPV_GAP = BPV_GAP_CYCLES,
  parameter int DEPTH = CELL_DEPTH,
  parameter int CNT_W = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // switches and button, asynchronous pins, 1 = up / pressed
  input wire logic [1:0] guard_switch_bank,
  input wire logic [11:0] option_switch_bank,
  input wire logic loop_button,
  // self-test engine, same clock
  input wire logic selftest_done,
  input wire logic selftest_pass,
  output logic selftest_start,
  // fast line receive, on its own link clock
  input wire logic fast_link_clk,
  input wire logic fast_cell_valid,
  input wire logic fast_cell_idle,
  input wire logic fast_hec_error,
  // slow line, same clock
  input wire logic slow_cell_req,
  input wire logic slow_hec_error,
  input wire logic slow_bipolar_violation,
  output logic slow_cell_send,
  output logic fast_cell_drop,
  // alarm conditions, asynchronous pins
  input wire alarm_type fast_alarm_in,
  input wire alarm_type slow_alarm_in,
  output alarm_type fast_alarm_out,
  output alarm_type slow_alarm_out,
  output logic fast_hec_relay,
  output logic slow_hec_relay,
  output logic fast_bipolar_violation,
  // line configuration
  output timing_type slow_tx_timing,
  output cable_type fast_cable,
  output cable_type slow_cable,
  output logic test_mode,
  output logic fast_loop_relay,
  output logic slow_loop_relay,
  // indicators
  output logic led_lamp_test,
  output logic led_active_green,
  output logic led_active_red,
  output logic led_loop,
  output logic led_overflow
);

  localparam int LVL_W = 2 + 12 + 1 + 8 + 4;
  localparam int DEP_W = $clog2(DEPTH + 1);

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c,
                                           input logic clr, input logic ev);
    if (clr)
      bump = ev ? CNT_W'(1) : '0;
    else
      bump = ev ? c + CNT_W'(1) : c;
  endfunction

  // two-flop synchronisers for every pin input
  logic [LVL_W-1:0] pin_meta;
  logic [LVL_W-1:0] pin_sync;
  always_ff @(posedge clk)
  begin
    pin_meta <= {guard_switch_bank, option_switch_bank, loop_button,
                 fast_alarm_in, slow_alarm_in, fast_link_clk,
                 fast_cell_valid, fast_cell_idle, fast_hec_error};
    pin_sync <= pin_meta;
  end

  logic [1:0] guard;
  logic [11:0] option;
  logic button;
  alarm_type fast_alarm;
  alarm_type slow_alarm;
  logic link_clk_s;
  logic cell_valid_s;
  logic cell_idle_s;
  logic hec_s;
  assign {guard, option, button, fast_alarm, slow_alarm, link_clk_s,
          cell_valid_s, cell_idle_s, hec_s} = pin_sync;

  // fast line events are taken on the sampled rising link edge
  logic link_clk_d;
  logic link_edge;
  always_ff @(posedge clk)
    link_clk_d <= link_clk_s;
  assign link_edge = link_clk_s & ~link_clk_d;

  // configuration gate and terminal overrides
  logic term_enable;
  logic cfg_open;
  logic sync_forced;
  timing_type sync_term;
  logic wr_stb;
  logic [7:0] wr_addr;
  assign cfg_open = ~guard[0] & term_enable;

  // ahb-lite slave: zero wait, reads prepared in the address phase
  logic addr_ok;
  logic [31:0] rd_value;
  logic [7:0] a;
  assign addr_ok = hsel & htrans[1] & hready;
  assign a = {haddr[7:2], 2'b00};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_stb <= addr_ok & hwrite & (haddr[31:8] == 24'h00_0000);
      wr_addr <= a;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok & ~hwrite)
        hrdata <= (haddr[31:8] == 24'h00_0000) ? rd_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      term_enable <= 1'b0;
      sync_forced <= 1'b0;
      sync_term <= TIME_INTERNAL;
    end
    else if (wr_stb)
    begin
      if (wr_addr == ADDR_OVERRIDE)
        term_enable <= hwdata[0];
      if (wr_addr == ADDR_SYNC && cfg_open)
      begin
        sync_forced <= 1'b1;
        case (hwdata[1:0])
          2'(SYNC_ARG_SLOW): sync_term <= TIME_SLOW;
          2'(SYNC_ARG_FAST): sync_term <= TIME_FAST;
          2'(SYNC_ARG_INT): sync_term <= TIME_INTERNAL;
          default: sync_forced <= sync_forced;
        endcase
      end
    end
  end

  // timing source, cable lengths and mode
  timing_type next_timing;
  logic any_los;
  assign any_los = fast_alarm.los | slow_alarm.los;
  always_comb
  begin
    if (any_los)
      next_timing = TIME_INTERNAL;
    else if (sync_forced)
      next_timing = sync_term;
    else if (option[0] & option[1])
      next_timing = TIME_INTERNAL;
    else if (option[0])
      next_timing = TIME_FAST;
    else
      next_timing = TIME_SLOW;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slow_tx_timing <= TIME_INTERNAL;
      fast_cable <= CABLE_SHORT;
      slow_cable <= CABLE_SHORT;
      test_mode <= 1'b0;
    end
    else
    begin
      slow_tx_timing <= next_timing;
      case (option[3:2])
        2'b11: fast_cable <= CABLE_LONG;
        2'b01: fast_cable <= CABLE_MEDIUM;
        default: fast_cable <= CABLE_SHORT;
      endcase
      slow_cable <= option[8] ? CABLE_LONG : CABLE_SHORT;
      test_mode <= ~option[6];
    end
  end

  // power-up self-test sequencing
  selftest_type st_state;
  logic [1:0] st_tries;
  logic [31:0] led_timer;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_state <= ST_RUN;
      st_tries <= 2'd0;
      led_timer <= 32'd0;
      selftest_start <= 1'b0;
      led_active_green <= 1'b0;
      led_active_red <= 1'b0;
    end
    else
    begin
      selftest_start <= 1'b0;
      case (st_state)
        ST_RUN:
        begin
          selftest_start <= 1'b1;
          st_tries <= st_tries + 2'd1;
          st_state <= ST_WAIT;
        end
        ST_WAIT:
          if (selftest_done)
          begin
            if (selftest_pass)
            begin
              led_active_green <= 1'b1;
              st_state <= ST_LOOP_LED;
            end
            else if (st_tries < 2'(SELFTEST_TRIES))
              st_state <= ST_RUN;
            else
            begin
              led_active_red <= 1'b1;
              st_state <= ST_LOOP_LED;
            end
            led_timer <= 32'(LOOP_LED_S * SEC_CYC);
          end
        ST_LOOP_LED:
          if (led_timer <= 32'd1)
            st_state <= ST_DONE;
          else
            led_timer <= led_timer - 32'd1;
        ST_DONE:
          st_state <= ST_DONE;
        default:
          st_state <= ST_RUN;
      endcase
    end
  end

  // remote loop: button hold, terminal command, auto release
  logic [31:0] hold_cnt;
  logic hold_latched;
  logic button_fire;
  logic term_start;
  logic term_stop;
  logic loop_active;
  logic [31:0] loop_secs;
  logic [31:0] sec_cnt;
  assign term_start = wr_stb & (wr_addr == ADDR_LOOP)
                      & ~hwdata[LOOP_STOP_BIT] & (hwdata[15:0] != 16'h0000);
  assign term_stop = wr_stb & (wr_addr == ADDR_LOOP) & hwdata[LOOP_STOP_BIT];
  // gate on the live level too, so a release or a guard flip in the
  // terminal cycle cannot still toggle the loop
  assign button_fire = button & ~guard[1] & ~hold_latched
                       & (hold_cnt == 32'(BUTTON_HOLD_S * SEC_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (srst || !button || guard[1])
    begin
      hold_cnt <= 32'd0;
      hold_latched <= 1'b0;
    end
    else if (button_fire)
      hold_latched <= 1'b1;
    else if (!hold_latched)
      hold_cnt <= hold_cnt + 32'd1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      loop_active <= 1'b0;
      loop_secs <= 32'd0;
      sec_cnt <= 32'd0;
    end
    else if (term_stop || (button_fire && loop_active))
      loop_active <= 1'b0;
    else if (term_start || button_fire)
    begin
      loop_active <= 1'b1;
      loop_secs <= term_start ? {16'h0000, hwdata[15:0]}
                              : 32'(LOOP_AUTO_S);
      sec_cnt <= 32'd0;
    end
    else if (loop_active)
    begin
      if (sec_cnt == 32'(SEC_CYC - 1))
      begin
        sec_cnt <= 32'd0;
        loop_secs <= loop_secs - 32'd1;
        if (loop_secs == 32'd1)
          loop_active <= 1'b0;
      end
      else
        sec_cnt <= sec_cnt + 32'd1;
    end
  end

  // both relays always from one flag, so one side never loops alone
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fast_loop_relay <= 1'b0;
      slow_loop_relay <= 1'b0;
      led_loop <= 1'b0;
      led_lamp_test <= 1'b0;
    end
    else
    begin
      fast_loop_relay <= loop_active;
      slow_loop_relay <= loop_active;
      led_loop <= loop_active || st_state == ST_LOOP_LED
                  || st_state == ST_RUN || st_state == ST_WAIT;
      led_lamp_test <= st_state == ST_RUN || st_state == ST_WAIT;
    end
  end

  // fast-to-slow cell buffer occupancy; cell storage sits in the datapath
  logic [DEP_W-1:0] fill;
  logic take;
  logic give;
  logic overflow;
  logic clear_stb;
  assign clear_stb = wr_stb & (wr_addr == ADDR_CLEAR);
  assign take = link_edge & cell_valid_s & ~cell_idle_s
                & (fill != DEP_W'(DEPTH) | give);
  assign give = slow_cell_req & (fill != '0);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fill <= '0;
      slow_cell_send <= 1'b0;
      fast_cell_drop <= 1'b0;
      overflow <= 1'b0;
      led_overflow <= 1'b0;
    end
    else
    begin
      fill <= fill + DEP_W'(take) - DEP_W'(give);
      slow_cell_send <= give;
      fast_cell_drop <= link_edge & cell_valid_s & ~take;
      // a new overflow in the clear cycle wins over the clear
      if (link_edge && cell_valid_s && !cell_idle_s && !take)
        overflow <= 1'b1;
      else if (clear_stb)
        overflow <= 1'b0;
      led_overflow <= overflow;
    end
  end

  // alarm and error relay
  logic [31:0] bpv_gap;
  logic bpv_pass;
  assign bpv_pass = option[7] & slow_bipolar_violation
                    & (bpv_gap == 32'd0);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fast_alarm_out <= '0;
      slow_alarm_out <= '0;
      fast_hec_relay <= 1'b0;
      slow_hec_relay <= 1'b0;
      fast_bipolar_violation <= 1'b0;
      bpv_gap <= 32'd0;
    end
    else
    begin
      fast_alarm_out <= slow_alarm;
      slow_alarm_out <= fast_alarm;
      slow_hec_relay <= link_edge & hec_s;
      fast_hec_relay <= slow_hec_error;
      fast_bipolar_violation <= bpv_pass;
      if (bpv_pass)
        bpv_gap <= 32'(BPV_GAP - 1);
      else if (bpv_gap != 32'd0)
        bpv_gap <= bpv_gap - 32'd1;
    end
  end

  // status counters
  logic [CNT_W-1:0] fast_hec_cnt;
  logic [CNT_W-1:0] slow_hec_cnt;
  logic [CNT_W-1:0] fast_rx_cnt;
  logic [CNT_W-1:0] slow_tx_cnt;
  logic [CNT_W-1:0] bpv_cnt;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fast_hec_cnt <= '0;
      slow_hec_cnt <= '0;
      fast_rx_cnt <= '0;
      slow_tx_cnt <= '0;
      bpv_cnt <= '0;
    end
    else
    begin
      fast_hec_cnt <= bump(fast_hec_cnt, clear_stb,
                           link_edge & hec_s);
      slow_hec_cnt <= bump(slow_hec_cnt, clear_stb, slow_hec_error);
      fast_rx_cnt <= bump(fast_rx_cnt, clear_stb, link_edge & cell_valid_s);
      slow_tx_cnt <= bump(slow_tx_cnt, clear_stb, give);
      bpv_cnt <= bump(bpv_cnt, clear_stb, slow_bipolar_violation);
    end
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (a)
      ADDR_OVERRIDE: rd_value = {30'h0, cfg_open, term_enable};
      ADDR_SYNC: rd_value = {29'h0, sync_forced, slow_tx_timing};
      ADDR_LOOP: rd_value = {loop_active, 15'h0, loop_secs[15:0]};
      ADDR_STATUS: rd_value = {8'h00, fast_alarm, slow_alarm, 6'h00,
                               overflow, led_active_red, led_active_green,
                               st_state == ST_DONE, 1'b0, test_mode,
                               4'(fill)};
      ADDR_HEC_CNT: rd_value = {slow_hec_cnt, fast_hec_cnt};
      ADDR_CELL_CNT: rd_value = {slow_tx_cnt, fast_rx_cnt};
      ADDR_BPV_CNT: rd_value = {16'h0000, bpv_cnt};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  los_fallback_a: assert property (
    any_los |=> slow_tx_timing == TIME_INTERNAL)
    else $error("timing not internal after loss of signal");
  loops_paired_a: assert property (fast_loop_relay == slow_loop_relay)
    else $error("loop relays differ");
  idle_drop_a: assert property (
    link_edge & cell_valid_s & cell_idle_s |=> fast_cell_drop)
    else $error("idle cell not dropped");
  fill_bound_a: assert property (fill <= DEP_W'(DEPTH))
    else $error("buffer fill above depth");
  overflow_flag_a: assert property (
    link_edge & cell_valid_s & ~cell_idle_s & ~take |=> overflow)
    else $error("overflow not flagged");
  bpv_gate_a: assert property (
    fast_bipolar_violation |-> $past(option[7]))
    else $error("violation relayed while disabled");
  bpv_spacing_a: assert property (
    fast_bipolar_violation |=> !fast_bipolar_violation)
    else $error("violations relayed back to back");
  button_guard_a: assert property (guard[1] |-> !button_fire)
    else $error("button accepted while disabled");
  cfg_refused_a: assert property (
    guard[0] & wr_stb & wr_addr == ADDR_SYNC |=> $stable(sync_term))
    else $error("sync changed while guarded");
  self_fail_a: assert property (
    led_active_red |-> st_tries == 2'(SELFTEST_TRIES))
    else $error("red before three attempts");
  term_stop_a: assert property (term_stop |=> ##1 !fast_loop_relay)
    else $error("loop not cancelled");
  hec_relay_a: assert property (slow_hec_error |=> fast_hec_relay)
    else $error("header error not relayed");

  loop_start_c: cover property (!loop_active ##1 loop_active);
  overflow_c: cover property ($rose(overflow));
  selftest_pass_c: cover property ($rose(led_active_green));
  selftest_fail_c: cover property ($rose(led_active_red));

endmodule // rate_adapter_ctrl

// File: test/fast_trunk_model.sv
// behavioural trunk port sending cells on the fast line
module fast_trunk_model (
  // fast line toward the adapter
  output logic link_clk,
  output logic cell_valid,
  output logic cell_idle,
  output logic hec_error
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    link_clk = 1'b0;
    cell_valid = 1'b0;
    cell_idle = 1'b1;
    hec_error = 1'b1;
  end

  // one cell per link period; the clock stands still between cells
  task automatic send_cell(input logic idle, input logic hec);
    #5;
    cell_valid = 1'b1;
    cell_idle = idle;
    hec_error = hec;
    #160;
    link_clk = 1'b1;
    #160;
    link_clk = 1'b0;
    // released lines flip so a stale value never passes for data
    cell_valid = 1'b0;
    cell_idle = ~idle;
    hec_error = ~hec;
  endtask

  task automatic send_burst(input int n, input logic idle);
    repeat (n)
    begin
      send_cell(idle, 1'b0);
      #40;
    end
  endtask
endmodule // fast_trunk_model

// File: test/tb.sv
// self-checking bench of the cell rate adapter control block
module tb
  import rate_adapter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 100;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, selftest_start, slow_cell_send, fast_cell_drop;
  logic fast_hec_relay, slow_hec_relay, fast_bipolar_violation, test_mode;
  logic fast_loop_relay, slow_loop_relay, led_lamp_test, led_active_green;
  logic led_active_red, led_loop, led_overflow;
  logic fast_link_clk, fast_cell_valid, fast_cell_idle, fast_hec_error;
  logic [1:0] guard_switch_bank = GUARD_RESET;
  logic [11:0] option_switch_bank = OPTION_RESET;
  logic loop_button = 1'b0;
  logic selftest_done = 1'b0;
  logic selftest_pass = 1'b0;
  logic slow_cell_req = 1'b0;
  logic slow_hec_error = 1'b0;
  logic slow_bipolar_violation = 1'b0;
  alarm_type fast_alarm_in = 4'h0;
  alarm_type slow_alarm_in = 4'h0;
  alarm_type fast_alarm_out, slow_alarm_out;
  timing_type slow_tx_timing;
  cable_type fast_cable, slow_cable;
  logic [1:0] loops;
  int error_cnt, comparisons, cycles, n_drop, n_send, n_fhec, n_shec, n_bpv;

  typedef struct packed {
    logic [11:0] opt;
    alarm_type fa;
    alarm_type sa;
    timing_type tim;
    cable_type fc;
    cable_type sc;
    logic tm;
  } row_type;
  // switch settings and alarm inputs with the line settings and relayed alarms they give
  row_type rows [5] = '{
    '{12'h14F, 4'h8, 4'h4, TIME_INTERNAL, CABLE_LONG, CABLE_LONG, 1'b0},
    '{12'h005, 4'h1, 4'h0, TIME_FAST, CABLE_MEDIUM, CABLE_SHORT, 1'b1},
    '{12'h040, 4'h0, 4'h0, TIME_SLOW, CABLE_SHORT, CABLE_SHORT, 1'b0},
    '{12'h040, 4'h0, 4'h2, TIME_INTERNAL, CABLE_SHORT, CABLE_SHORT, 1'b0},
    '{12'h005, 4'h2, 4'h0, TIME_INTERNAL, CABLE_MEDIUM, CABLE_SHORT, 1'b1}
  };
  timing_type sync_want [3] = '{TIME_SLOW, TIME_FAST, TIME_INTERNAL};

  assign loops = {fast_loop_relay, slow_loop_relay};

  rate_adapter_ctrl #(.SEC_CYC(SEC), .BPV_GAP(20)) DUT (
    .clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .guard_switch_bank, .option_switch_bank, .loop_button,
    .selftest_done, .selftest_pass, .selftest_start,
    .fast_link_clk, .fast_cell_valid, .fast_cell_idle, .fast_hec_error,
    .slow_cell_req, .slow_hec_error, .slow_bipolar_violation,
    .slow_cell_send, .fast_cell_drop,
    .fast_alarm_in, .slow_alarm_in, .fast_alarm_out, .slow_alarm_out,
    .fast_hec_relay, .slow_hec_relay, .fast_bipolar_violation,
    .slow_tx_timing, .fast_cable, .slow_cable, .test_mode,
    .fast_loop_relay, .slow_loop_relay,
    .led_lamp_test, .led_active_green, .led_active_red, .led_loop,
    .led_overflow
  );

  fast_trunk_model trunk (
    .link_clk(fast_link_clk),
    .cell_valid(fast_cell_valid),
    .cell_idle(fast_cell_idle),
    .hec_error(fast_hec_error)
  );

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    n_drop += int'(fast_cell_drop === 1'b1);
    n_send += int'(slow_cell_send === 1'b1);
    n_fhec += int'(fast_hec_relay === 1'b1);
    n_shec += int'(slow_hec_relay === 1'b1);
    n_bpv += int'(fast_bipolar_violation === 1'b1);
    if (cycles == LIMIT)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do
      cyc(1);
    while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do
      cyc(1);
    while (hreadyout !== 1'b1);
    rd = hrdata;
    check("okay", 32'(hresp), 32'h0);
  endtask

  task automatic reset_dut();
    srst <= 1'b1;
    cyc(12);
    check("reset loop", 32'(loops), 32'h0);
    check("reset timing", 32'(slow_tx_timing), 32'(TIME_INTERNAL));
    srst <= 1'b0;
  endtask

  // answers each attempt; the attempt after `fails` failures passes
  task automatic selftest(input int fails);
    int k;
    for (int i = 0; i < SELFTEST_TRIES && i <= fails; i++)
    begin
      k = 0;
      while (selftest_start !== 1'b1 && k < 40)
      begin
        cyc(1);
        k++;
      end
      check("start", 32'(selftest_start), 32'h1);
      cyc(2);
      check("lamp test", 32'(led_lamp_test), 32'h1);
      check("active dark", 32'(led_active_green | led_active_red), 0);
      selftest_done <= 1'b1;
      selftest_pass <= 1'(i == fails);
      cyc(1);
      selftest_done <= 1'b0;
    end
    cyc(4);
    check("green", 32'(led_active_green), 32'(fails < 3));
    check("red", 32'(led_active_red), 32'(fails >= 3));
    check("loop lamp on", 32'(led_loop), 32'h1);
    cyc(LOOP_LED_S * SEC + 8);
    check("loop lamp off", 32'(led_loop), 32'h0);
  endtask

  task automatic press(input int n);
    loop_button <= 1'b1;
    cyc(n);
    loop_button <= 1'b0;
    cyc(8);
  endtask

  task automatic bipolar_violation(input int gap);
    slow_bipolar_violation <= 1'b1;
    cyc(1);
    slow_bipolar_violation <= 1'b0;
    cyc(gap);
  endtask

  initial
  begin
    reset_dut();
    selftest(2);
    foreach (rows[i])
    begin
      option_switch_bank <= rows[i].opt;
      fast_alarm_in <= rows[i].fa;
      slow_alarm_in <= rows[i].sa;
      cyc(8);
      check("timing", 32'(slow_tx_timing), 32'(rows[i].tim));
      check("fast cable", 32'(fast_cable), 32'(rows[i].fc));
      check("slow cable", 32'(slow_cable), 32'(rows[i].sc));
      check("test mode", 32'(test_mode), 32'(rows[i].tm));
      check("to fast", 32'(fast_alarm_out), 32'(rows[i].sa));
      check("to slow", 32'(slow_alarm_out), 32'(rows[i].fa));
    end
    option_switch_bank <= 12'h040;
    fast_alarm_in <= 4'h0;
    slow_alarm_in <= 4'h0;
    cyc(8);
    bus(1'b1, ADDR_OVERRIDE, 32'h1);
    bus(1'b1, ADDR_SYNC, 32'(SYNC_ARG_FAST));
    cyc(2);
    check("guarded", 32'(slow_tx_timing), 32'(TIME_SLOW));
    guard_switch_bank <= 2'b10;
    cyc(6);
    bus(1'b1, ADDR_OVERRIDE, 32'h0);
    bus(1'b1, ADDR_SYNC, 32'(SYNC_ARG_FAST));
    cyc(2);
    check("override off", 32'(slow_tx_timing), 32'(TIME_SLOW));
    bus(1'b1, ADDR_OVERRIDE, 32'h1);
    bus(1'b0, ADDR_OVERRIDE, 32'h0);
    check("config open", 32'(rd[1]), 32'h1);
    for (int i = 2; i >= 0; i--)
    begin
      bus(1'b1, ADDR_SYNC, 32'(i));
      cyc(2);
      check("sync", 32'(slow_tx_timing), 32'(sync_want[i]));
    end
    bus(1'b0, ADDR_SYNC, 32'h0);
    check("sync read", rd, 32'h4 | 32'(TIME_SLOW));
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    // slow side stalls while the burst arrives
    trunk.send_burst(3, 1'b1);
    cyc(6);
    check("idle drops", n_drop, 3);
    trunk.send_burst(CELL_DEPTH, 1'b0);
    cyc(6);
    check("burst kept", n_drop, 3);
    check("no overflow", 32'(led_overflow), 32'h0);
    trunk.send_burst(1, 1'b0);
    cyc(6);
    check("full drop", n_drop, 4);
    check("overflow", 32'(led_overflow), 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status overflow", 32'(rd[9]), 32'h1);
    repeat (CELL_DEPTH + 5)
    begin
      slow_cell_req <= 1'b1;
      cyc(1);
      slow_cell_req <= 1'b0;
      cyc(2);
    end
    check("cells out", n_send, CELL_DEPTH);
    bus(1'b0, ADDR_CELL_CNT, 32'h0);
    check("tx count", 32'(rd[31:16]), CELL_DEPTH);
    bus(1'b1, ADDR_CLEAR, 32'h0);
    bus(1'b0, ADDR_CELL_CNT, 32'h0);
    check("cleared", rd, 32'h0);
    check("overflow cleared", 32'(led_overflow), 32'h0);
    trunk.send_cell(1'b0, 1'b1);
    cyc(6);
    check("hec to slow", n_shec, 1);
    slow_hec_error <= 1'b1;
    cyc(1);
    slow_hec_error <= 1'b0;
    cyc(4);
    check("hec to fast", n_fhec, 1);
    bus(1'b0, ADDR_HEC_CNT, 32'h0);
    check("hec counts", rd, 32'h0001_0001);
    option_switch_bank <= 12'h0C0;
    cyc(6);
    bipolar_violation(2);
    bipolar_violation(30);
    bipolar_violation(30);
    check("violations", n_bpv, 2);
    option_switch_bank <= 12'h040;
    cyc(6);
    bipolar_violation(30);
    check("violations off", n_bpv, 2);
    bus(1'b0, ADDR_BPV_CNT, 32'h0);
    check("bpv count", rd, 32'h4);
    guard_switch_bank <= 2'b11;
    cyc(6);
    press(SEC + 50);
    check("button off", 32'(loops), 32'h0);
    guard_switch_bank <= 2'b01;
    cyc(6);
    press(SEC / 2);
    check("short hold", 32'(loops), 32'h0);
    press(SEC + 50);
    check("button loop", 32'(loops), 32'h3);
    press(SEC + 50);
    check("second press", 32'(loops), 32'h0);
    bus(1'b1, ADDR_LOOP, 32'h2);
    cyc(100);
    check("terminal loop", 32'(loops), 32'h3);
    bus(1'b1, ADDR_LOOP, 32'h2);
    cyc(180);
    check("loop restarted", 32'(loops), 32'h3);
    cyc(40);
    check("loop expired", 32'(loops), 32'h0);
    bus(1'b1, ADDR_LOOP, 32'h5);
    cyc(8);
    check("loop again", 32'(loops), 32'h3);
    bus(1'b0, ADDR_LOOP, 32'h0);
    check("loop read", 32'(rd[31]), 32'h1);
    bus(1'b1, ADDR_LOOP, 32'h80000000);
    cyc(4);
    check("loop stopped", 32'(loops), 32'h0);
    reset_dut();
    selftest(SELFTEST_TRIES);
    end_of_test();
  end
endmodule // tb
